// [rtl/jsl_link_init.sv]
// Contract
// - Select 0: single-ended sync pin is the active-low link request in 8b/10b.
// - In 8b/10b, sync low starts code group synchronization on the lanes.
// - Receiver raises sync after sync; rising level starts lane alignment sequence.
// - In 64b/66b, sync never drives link bring-up; only NCO sync.
// - Select 1: sync comes from differential timestamp pair; board ties pin low.
// - Power-down high disables every serializer output.
`timescale 1ns/1ps
module jsl_link_init
  import jsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sync_sel,
  input wire logic mode_64b66b,
  input wire logic single_ended_sync_pin,
  input wire logic timestamp_diff_pair,
  input wire logic power_down_pin,
  output logic serializer_en,
  output jsl_pkg::jsl_lane_e lane_content,
  output logic ilas_start,
  output logic nco_sync
);
  import jsl_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  jsl_sync_if sync_bus ();

  jsl_sync_sel u_sel (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sync_sel(sync_sel),
    .single_ended_sync_pin(single_ended_sync_pin),
    .timestamp_diff_pair(timestamp_diff_pair),
    .sync_o(sync_bus.src)
  );

  logic sync_n;
  logic sync_fall;
  assign sync_n = sync_bus.sync_n;
  assign sync_fall = sync_bus.sync_fall;

  jsl_state_e state_d;
  jsl_state_e state_q;
  logic [JSL_CNT_W-1:0] cnt_d;
  logic [JSL_CNT_W-1:0] cnt_q;
  logic mode_d;
  logic mode_q;
  logic ser_d;
  logic ser_q;
  jsl_lane_e lane_d;
  jsl_lane_e lane_q;
  logic ilas_d;
  logic ilas_q;
  logic nco_d;
  logic nco_q;

  // ****************************************************
  // Link bring-up sequencer
  // ****************************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    mode_d = mode_64b66b;
    ilas_d = 1'b0;
    nco_d = mode_64b66b && sync_fall;
    if (power_down_pin) begin
      state_d = JSL_ST_OFF;
    end else if (mode_64b66b != mode_q) begin
      // Mode swap mid-link: restart clean rather than mix encodings
      state_d = JSL_ST_IDLE;
    end else if (mode_64b66b) begin
      state_d = JSL_ST_DATA;
    end else begin
      case (state_q)
        JSL_ST_OFF: begin
          state_d = JSL_ST_IDLE;
        end
        JSL_ST_IDLE: begin
          if (!sync_n) begin
            state_d = JSL_ST_CGS;
          end
        end
        JSL_ST_CGS: begin
          if (sync_n) begin
            state_d = JSL_ST_ILAS;
            cnt_d = JSL_CNT_RST;
            ilas_d = 1'b1;
          end
        end
        JSL_ST_ILAS: begin
          if (!sync_n) begin
            state_d = JSL_ST_CGS;
          end else if (cnt_q == JSL_ILAS_LAST) begin
            state_d = JSL_ST_DATA;
          end else begin
            cnt_d = cnt_q + 5'h0_001;
          end
        end
        JSL_ST_DATA: begin
          if (!sync_n) begin
            state_d = JSL_ST_CGS;
          end
        end
        default: begin
          state_d = JSL_ST_IDLE;
        end
      endcase
    end
    ser_d = (state_d != JSL_ST_OFF);
    case (state_d)
      JSL_ST_CGS: lane_d = JSL_LANE_CGS;
      JSL_ST_ILAS: lane_d = JSL_LANE_ILAS;
      JSL_ST_DATA: lane_d = JSL_LANE_DATA;
      default: lane_d = JSL_LANE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= JSL_ST_OFF;
      cnt_q <= JSL_CNT_RST;
      mode_q <= 1'b0;
      ser_q <= 1'b0;
      lane_q <= JSL_LANE_IDLE;
      ilas_q <= 1'b0;
      nco_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      ser_q <= ser_d;
      lane_q <= lane_d;
      ilas_q <= ilas_d;
      nco_q <= nco_d;
    end
  end

  assign serializer_en = ser_q;
  assign lane_content = lane_q;
  assign ilas_start = ilas_q;
  assign nco_sync = nco_q;

  // ****************************************************
  // Checks
  // ****************************************************
  logic run8;
  assign run8 = !power_down_pin && !mode_64b66b && (mode_64b66b == mode_q);

  property p_cgs_on_low;
    (run8 && !sync_n && state_q != JSL_ST_OFF) |=> (lane_content == JSL_LANE_CGS);
  endproperty
  a_cgs_on_low: assert property (p_cgs_on_low)
    else $error("sync low did not start code group sync");

  property p_ilas_on_rise;
    (run8 && sync_n && state_q == JSL_ST_CGS)
      |=> (ilas_start && lane_content == JSL_LANE_ILAS);
  endproperty
  a_ilas_on_rise: assert property (p_ilas_on_rise)
    else $error("sync high after sync did not start alignment");

  property p_ilas_only_after_cgs;
    ilas_start |-> ($past(state_q) == JSL_ST_CGS && $past(sync_n));
  endproperty
  a_ilas_only_after_cgs: assert property (p_ilas_only_after_cgs)
    else $error("alignment started without finished sync");

  property p_ilas_len;
    (state_q == JSL_ST_ILAS && cnt_q == JSL_ILAS_LAST && run8 && sync_n)
      |=> (lane_content == JSL_LANE_DATA);
  endproperty
  a_ilas_len: assert property (p_ilas_len)
    else $error("alignment did not end into data");

  property p_64_ignores_sync;
    (!power_down_pin && mode_64b66b && mode_q) [*2]
      |=> (lane_content == JSL_LANE_DATA && !ilas_start);
  endproperty
  a_64_ignores_sync: assert property (p_64_ignores_sync)
    else $error("64b/66b link reacted to sync");

  property p_nco_pulse;
    (mode_64b66b && sync_fall) |=> nco_sync;
  endproperty
  a_nco_pulse: assert property (p_nco_pulse)
    else $error("sync edge not passed to NCO");

  property p_pd_off;
    power_down_pin |=> (!serializer_en ##1 (!serializer_en || !$past(power_down_pin)));
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("serializer on during power-down");

  property p_data_abort;
    (run8 && state_q == JSL_ST_DATA && !sync_n) |=> (lane_content == JSL_LANE_CGS);
  endproperty
  a_data_abort: assert property (p_data_abort)
    else $error("data kept after sync request");

  property p_pd_lane_idle;
    power_down_pin |=> (lane_content == JSL_LANE_IDLE && !ilas_start);
  endproperty
  a_pd_lane_idle: assert property (p_pd_lane_idle)
    else $error("lanes active during power-down");

  property p_ilas_pulse;
    ilas_start |=> !ilas_start;
  endproperty
  a_ilas_pulse: assert property (p_ilas_pulse)
    else $error("alignment start pulse longer than one cycle");

  property p_ilas_hold;
    (run8 && sync_n && state_q == JSL_ST_ILAS && cnt_q != JSL_ILAS_LAST)
      |=> (lane_content == JSL_LANE_ILAS);
  endproperty
  a_ilas_hold: assert property (p_ilas_hold)
    else $error("alignment sequence cut short");

  c_ilas: cover property (ilas_start);
  c_data8: cover property (!mode_q && lane_content == JSL_LANE_DATA);
  c_resync: cover property (state_q == JSL_ST_DATA ##1 state_q == JSL_ST_CGS);
  c_pd: cover property (serializer_en ##1 !serializer_en);

endmodule

// [rtl/jsl_pkg.sv]
package jsl_pkg;

  // ****************************************************
  // Link states and lane content
  // ****************************************************
  typedef enum logic [2:0] {
    JSL_ST_OFF,
    JSL_ST_IDLE,
    JSL_ST_CGS,
    JSL_ST_ILAS,
    JSL_ST_DATA
  } jsl_state_e;

  typedef enum logic [1:0] {
    JSL_LANE_IDLE,
    JSL_LANE_CGS,
    JSL_LANE_ILAS,
    JSL_LANE_DATA
  } jsl_lane_e;

  // ****************************************************
  // Select codes, reset values, timing
  // ****************************************************
  localparam logic JSL_SEL_SINGLE = 1'b0;
  localparam logic JSL_SEL_DIFF = 1'b1;
  localparam logic JSL_SYNC_RST = 1'b1;
  localparam int JSL_ILAS_CYCLES = 16;
  localparam int JSL_CNT_W = 5;
  localparam logic [JSL_CNT_W-1:0] JSL_ILAS_LAST = 5'h0_00F;
  localparam logic [JSL_CNT_W-1:0] JSL_CNT_RST = 5'h0_000;

endpackage

// [rtl/jsl_sync_if.sv]
`timescale 1ns/1ps
interface jsl_sync_if;
  logic sync_n;
  logic sync_fall;

  modport src (output sync_n, output sync_fall);
  modport dst (input sync_n, input sync_fall);
endinterface

// [rtl/jsl_sync_sel.sv]
`timescale 1ns/1ps
module jsl_sync_sel
  import jsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sync_sel,
  input wire logic single_ended_sync_pin,
  input wire logic timestamp_diff_pair,
  jsl_sync_if.src sync_o
);

  logic sync_n_d;
  logic sync_n_q;
  logic fall_d;
  logic fall_q;

  // ****************************************************
  // Source select, registered
  // ****************************************************
  always_comb begin
    if (sync_sel == JSL_SEL_DIFF) begin
      sync_n_d = timestamp_diff_pair;
    end else begin
      sync_n_d = single_ended_sync_pin;
    end
    fall_d = sync_n_q && !sync_n_d;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync_n_q <= JSL_SYNC_RST;
      fall_q <= 1'b0;
    end else begin
      sync_n_q <= sync_n_d;
      fall_q <= fall_d;
    end
  end

  assign sync_o.sync_n = sync_n_q;
  assign sync_o.sync_fall = fall_q;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_single_src;
    @(posedge clk_sys) disable iff (!reset_n)
    (sync_sel == JSL_SEL_SINGLE) |=> (sync_n_q == $past(single_ended_sync_pin));
  endproperty
  a_single_src: assert property (p_single_src)
    else $error("sync does not follow single-ended pin");

  property p_diff_src;
    @(posedge clk_sys) disable iff (!reset_n)
    (sync_sel == JSL_SEL_DIFF) |=> (sync_n_q == $past(timestamp_diff_pair));
  endproperty
  a_diff_src: assert property (p_diff_src)
    else $error("sync does not follow differential pair");

endmodule

// [sim/jsl_rx_model.sv]
`timescale 1ns/1ps
module jsl_rx_model
  import jsl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic resync,
  input wire logic sync_sel,
  input wire logic mode_64b66b,
  input wire logic [3:0] cgs_hold,
  input wire jsl_pkg::jsl_lane_e lane_content,
  output logic single_ended_sync_pin,
  output logic timestamp_diff_pair
);
  // ********
  // Receiver
  // ********
  logic sync_q, sync_d, noise_q;
  logic [3:0] cnt_q, cnt_d;
  always_comb begin
    sync_d = sync_q;
    cnt_d = cnt_q;
    if (resync) begin
      sync_d = 1'b0;
      cnt_d = 4'h0;
    end else if (!sync_q && (lane_content == JSL_LANE_CGS || mode_64b66b)) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == cgs_hold) sync_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync_q <= 1'b1;
      cnt_q <= 4'h0;
      noise_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      cnt_q <= cnt_d;
      noise_q <= ~noise_q;
    end
  end
  // Unused diff pair toggles so a stale level is never mistaken for sync; unused single-ended pin is tied low
  assign single_ended_sync_pin = sync_sel ? 1'b0 : sync_q;
  assign timestamp_diff_pair = sync_sel ? sync_q : noise_q;
endmodule

// [sim/jsl_sync_link_init_test.sv]
`timescale 1ns/1ps
module jsl_sync_link_init_test;
  import jsl_pkg::*;
  // *****
  // Bench
  // *****
  logic clk_sys, reset_n, sync_sel, mode_64b66b, power_down_pin, resync;
  logic single_ended_sync_pin, timestamp_diff_pair, serializer_en, ilas_start, nco_sync;
  logic [3:0] cgs_hold;
  logic [31:0] rng;
  jsl_lane_e lane_content;
  int n_mismatch, n_checks, cycles, n, bad;

  jsl_link_init dut (.clk_sys(clk_sys), .reset_n(reset_n), .sync_sel(sync_sel),
    .mode_64b66b(mode_64b66b), .single_ended_sync_pin(single_ended_sync_pin),
    .timestamp_diff_pair(timestamp_diff_pair), .power_down_pin(power_down_pin),
    .serializer_en(serializer_en), .lane_content(lane_content),
    .ilas_start(ilas_start), .nco_sync(nco_sync));
  jsl_rx_model rx (.clk_sys(clk_sys), .reset_n(reset_n), .resync(resync),
    .sync_sel(sync_sel), .mode_64b66b(mode_64b66b), .cgs_hold(cgs_hold),
    .lane_content(lane_content), .single_ended_sync_pin(single_ended_sync_pin),
    .timestamp_diff_pair(timestamp_diff_pair));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wait_lane(input jsl_lane_e exp, input int limit);
    int i;
    i = 0;
    while (lane_content !== exp && i < limit) begin
      @(negedge clk_sys);
      i++;
    end
  endtask

  task automatic pulse_resync;
    resync = 1'b1;
    @(negedge clk_sys);
    resync = 1'b0;
  endtask

  task automatic link_up(input logic sel);
    int k;
    rng = xs(rng);
    sync_sel = sel;
    cgs_hold = rng[3:0];
    pulse_resync();
    wait_lane(JSL_LANE_CGS, 4);
    check(lane_content, JSL_LANE_CGS);
    wait_lane(JSL_LANE_ILAS, 24);
    check(ilas_start, 1'b1);
    k = 0;
    while (lane_content === JSL_LANE_ILAS && k < 40) begin
      @(negedge clk_sys);
      k++;
    end
    check(8'(k), 8'(JSL_ILAS_CYCLES));
    check(lane_content, JSL_LANE_DATA);
    check(serializer_en, 1'b1);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    {n_mismatch, n_checks, cycles} = '0;
    rng = 32'h0000_0001;
    {reset_n, sync_sel, mode_64b66b, power_down_pin, resync} = '0;
    cgs_hold = 4'h0;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    link_up(1'b0);
    link_up(1'b1);
    for (int r = 0; r < 6; r++) begin
      link_up(rng[9]);
    end
    mode_64b66b = 1'b1;
    @(negedge clk_sys);
    wait_lane(JSL_LANE_DATA, 8);
    check(lane_content, JSL_LANE_DATA);
    pulse_resync();
    {n, bad} = '0;
    repeat (20) begin
      @(negedge clk_sys);
      n += nco_sync;
      bad += (lane_content !== JSL_LANE_DATA);
    end
    check(8'(n), 8'h01);
    check(8'(bad), 8'h00);
    mode_64b66b = 1'b0;
    link_up(1'b0);
    power_down_pin = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(serializer_en, 1'b0);
    power_down_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(serializer_en, 1'b1);
    link_up(1'b1);
    final_report();
  end
endmodule
